// >>> rtl/mode_one_pkg.sv
package mode_one_pkg;
   // -----------------------------------------------
   // Register map (byte-wide registers)
   // -----------------------------------------------
   localparam logic [3:0] MODE_ADDR     = 4'h0;
   localparam logic [3:0] CMD_ADDR      = 4'h1;
   localparam logic [3:0] MODE2_ADDR    = 4'h2;
   localparam logic [3:0] STAT_ADDR     = 4'h3;
   localparam logic [3:0] IRQ_STAT_ADDR = 4'h4;
   localparam logic [3:0] IRQ_MASK_ADDR = 4'h5;
   localparam logic [3:0] PTR_ADDR      = 4'h6;
   // -----------------------------------------------
   // Field positions of mode_config_first; TX_FLOW_BIT is in mode two
   // -----------------------------------------------
   localparam int RX_FLOW_BIT  = 7;
   localparam int REQ_SRC_BIT  = 6;
   localparam int ERR_MODE_BIT = 5;
   localparam int PM_HI_BIT    = 4;
   localparam int PM_LO_BIT    = 3;
   localparam int PT_BIT       = 2;
   localparam int BC_HI_BIT    = 1;
   localparam int BC_LO_BIT    = 0;
   localparam int TX_FLOW_BIT  = 5;
   // -----------------------------------------------
   // Reset values and command codes
   // -----------------------------------------------
   localparam logic [7:0] MODE1_RESET = 8'h00;
   localparam logic [7:0] MODE2_RESET = 8'h00;
   localparam logic [3:0] IRQ_RESET   = 4'h0;
   localparam logic [2:0] CMD_RST_PTR = 3'h1;
   localparam logic [2:0] CMD_RST_ERR = 3'h4;
   // -----------------------------------------------
   // Parity modes
   // -----------------------------------------------
   typedef enum logic [1:0] {
      PM_WITH  = 2'b00,
      PM_FORCE = 2'b01,
      PM_NONE  = 2'b10,
      PM_MULTI = 2'b11
   } parity_mode_t;
   typedef enum logic [1:0] {
      PAR_EVEN = 2'b00,
      PAR_ODD  = 2'b01,
      PAR_LOW  = 2'b10,
      PAR_HIGH = 2'b11
   } parity_sel_t;
endpackage : mode_one_pkg

// >>> rtl/uart_mode_config_first.sv
// Summary of operation
// - Pointer selects first register after reset/command
// - Access to first register advances pointer
// - Flow bit zero: receiver leaves RTS alone
// - Start bit with full FIFO negates RTS
// - RTS reasserted once FIFO has room
// - Both flow sources enabled disables both
// - Character mode: errors show FIFO head only
// - Block mode: errors OR-accumulate until reset
// - Mode 00 with type selects even/odd
// - 01 forces parity, 10 none, 11 multidrop
// - Length code gives 5 to 8 bits
module uart_mode_config_first
(
   // Clock and reset
   input  wire logic                     i_ref_clk,
   input  wire logic                     i_rst_n,
   // Register port
   input  wire logic [3:0]               i_addr,
   input  wire logic [7:0]               i_wdata,
   input  wire logic                     i_wr,
   input  wire logic                     i_rd,
   output logic      [7:0]               o_rdata,
   // Receiver events
   input  wire logic                     i_start_bit,
   input  wire logic                     i_fifo_full,
   input  wire logic                     i_rx_ready,
   input  wire logic                     i_head_pop,
   input  wire logic [3:0]               i_head_err,
   input  wire logic                     i_head_addr,
   input  wire logic                     i_rts_manual,
   // Configuration and outputs
   output logic                          o_request_to_send_out,
   output logic                          o_rx_request,
   output mode_one_pkg::parity_sel_t     o_parity_sel,
   output logic                          o_parity_enable,
   output logic                          o_multidrop,
   output logic [3:0]                    o_data_bits,
   output logic                          o_tx_flow_active,
   output logic                          o_irq
);
   import mode_one_pkg::*;

   // -----------------------------------------------
   // Address decode
   // -----------------------------------------------
   logic [7:0] mode1_q, mode2_q, rdata_q;
   logic       ptr_q, rts_hold_q;
   logic [3:0] err_q, irq_stat_q, irq_mask_q;
   logic       rts_prev_q;

   wire hit_mode  = (i_addr == MODE_ADDR);
   wire mode1_wr  = i_wr & hit_mode & ~ptr_q;
   wire mode2_wr  = i_wr & ((hit_mode & ptr_q) | (i_addr == MODE2_ADDR));
   wire mode1_acc = (i_wr | i_rd) & hit_mode & ~ptr_q;
   wire cmd_wr    = i_wr & (i_addr == CMD_ADDR);
   wire rst_ptr   = cmd_wr & (i_wdata[6:4] == CMD_RST_PTR);
   wire rst_err   = cmd_wr & (i_wdata[6:4] == CMD_RST_ERR);

   // -----------------------------------------------
   // Mode fields
   // -----------------------------------------------
   wire rx_flow   = mode1_q[RX_FLOW_BIT];
   wire tx_flow   = mode2_q[TX_FLOW_BIT];
   wire flow_clash = rx_flow & tx_flow;
   wire rx_flow_ok = rx_flow & ~flow_clash;
   wire err_block = mode1_q[ERR_MODE_BIT];
   wire [1:0] pm  = mode1_q[PM_HI_BIT:PM_LO_BIT];
   wire pt        = mode1_q[PT_BIT];
   wire [1:0] bc  = mode1_q[BC_HI_BIT:BC_LO_BIT];

   function automatic logic [3:0] char_bits(input logic [1:0] code);
      char_bits = 4'h5 + {2'b00, code};
   endfunction : char_bits

   // -----------------------------------------------
   // Registers
   // -----------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode1_q <= MODE1_RESET;
         mode2_q <= MODE2_RESET;
         ptr_q   <= 1'b0;
      end else begin
         if (mode1_wr) begin
            mode1_q <= i_wdata;
         end
         if (mode2_wr) begin
            mode2_q <= i_wdata;
         end
         if (rst_ptr) begin
            ptr_q <= 1'b0;
         end else if (mode1_acc) begin
            ptr_q <= 1'b1;
         end
      end
   end

   // Flow control hold: set on start bit while full, dropped when room
   wire rts_hold_d = rx_flow_ok & ((i_start_bit & i_fifo_full) |
                                   (rts_hold_q & i_fifo_full));
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rts_hold_q <= 1'b0;
      end else begin
         rts_hold_q <= rts_hold_d;
      end
   end
   // Flow bit clear leaves the manual level through untouched
   assign o_request_to_send_out = i_rts_manual & ~rts_hold_q;

   // Error status: head only, or sticky OR until the reset command
   wire [3:0] err_d = err_block ? (err_q | (i_head_pop ? i_head_err : 4'h0))
                                : (i_head_pop ? i_head_err : err_q);
   logic head_addr_q;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         err_q       <= 4'h0;
         head_addr_q <= 1'b0;
      end else begin
         err_q <= (rst_err & ~(err_block & i_head_pop)) ? 4'h0 : err_d;
         if (i_head_pop) begin
            head_addr_q <= i_head_addr;
         end
      end
   end

   // -----------------------------------------------
   // Interrupt status: bit0 rx request, bit1 rts drop, bit2 error, bit3 clash
   // -----------------------------------------------
   wire rx_req   = mode1_q[REQ_SRC_BIT] ? i_fifo_full : i_rx_ready;
   // Rising hold marks the RTS drop; both idle low after reset
   wire rts_fall = rts_hold_q & ~rts_prev_q;
   wire [3:0] irq_evt = {flow_clash, |(i_head_err & {4{i_head_pop}}), rts_fall, rx_req};
   wire irq_clr_wr = i_wr & (i_addr == IRQ_STAT_ADDR);
   wire [3:0] irq_clr = irq_clr_wr ? i_wdata[3:0] : 4'h0;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_stat_q <= IRQ_RESET;
         irq_mask_q <= IRQ_RESET;
         rts_prev_q <= 1'b0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;          // Set wins
         rts_prev_q <= rts_hold_q;
         if (i_wr & (i_addr == IRQ_MASK_ADDR)) begin
            irq_mask_q <= i_wdata[3:0];
         end
      end
   end
   assign o_irq        = |(irq_stat_q & irq_mask_q);
   assign o_rx_request = rx_req;

   // -----------------------------------------------
   // Parity and character length decode
   // -----------------------------------------------
   always_comb begin
      case (parity_mode_t'(pm))
         PM_WITH:  o_parity_sel = pt ? PAR_ODD : PAR_EVEN;
         PM_FORCE: o_parity_sel = pt ? PAR_HIGH : PAR_LOW;
         PM_MULTI: o_parity_sel = pt ? PAR_HIGH : PAR_LOW;
         default:  o_parity_sel = PAR_EVEN;
      endcase
   end
   assign o_parity_enable  = (pm != PM_NONE);
   assign o_multidrop      = (pm == PM_MULTI);
   assign o_data_bits      = char_bits(bc);
   assign o_tx_flow_active = tx_flow & ~flow_clash;

   // -----------------------------------------------
   // Read path, data one cycle after the strobe
   // -----------------------------------------------
   wire [7:0] stat_view = {2'b00, head_addr_q & ~err_block & o_multidrop, 1'b0, err_q};
   logic [7:0] rd_mux;
   always_comb begin
      case (i_addr)
         MODE_ADDR:     rd_mux = ptr_q ? mode2_q : mode1_q;
         MODE2_ADDR:    rd_mux = mode2_q;
         STAT_ADDR:     rd_mux = stat_view;
         IRQ_STAT_ADDR: rd_mux = {4'h0, irq_stat_q};
         IRQ_MASK_ADDR: rd_mux = {4'h0, irq_mask_q};
         PTR_ADDR:      rd_mux = {7'h00, ptr_q};
         default:       rd_mux = 8'h00;
      endcase
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_q <= 8'h00;
      end else begin
         // Zero outside the read cycle keeps stale data off the bus
         rdata_q <= i_rd ? rd_mux : 8'h00;
      end
   end
   assign o_rdata = rdata_q;

   // -----------------------------------------------
   // Pointer checks
   // -----------------------------------------------
   a_ptr_reset_cmd: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      rst_ptr |=> !ptr_q) else $error("pointer not reset by command");

   a_ptr_advance: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (mode1_acc && !rst_ptr) |=> ptr_q) else $error("pointer did not advance");

   // Accesses to the second register leave the pointer alone
   a_ptr_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (!rst_ptr && !mode1_acc) |=> (ptr_q == $past(ptr_q)))
      else $error("pointer moved without an access");

   // -----------------------------------------------
   // Flow control checks
   // -----------------------------------------------
   // A hold left from flow control drains one edge after the bit clears
   a_rts_no_effect: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (!rx_flow && !$past(rx_flow)) |-> (o_request_to_send_out == i_rts_manual))
      else $error("rts changed with flow off");

   a_hold_needs_flow: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !rx_flow_ok |=> !rts_hold_q) else $error("rts hold without flow control");

   // Hold is registered, so RTS drops on the edge after the start bit
   a_rts_negate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (rx_flow_ok && i_start_bit && i_fifo_full) |=> !o_request_to_send_out)
      else $error("rts not negated on full");

   a_rts_release: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (rts_hold_q && !i_fifo_full) |=> !rts_hold_q) else $error("rts hold stuck");

   // Neither source may touch RTS while both are enabled
   a_flow_clash: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      flow_clash |-> (!o_tx_flow_active ##1 !rts_hold_q)) else $error("clash not disabling");

   // -----------------------------------------------
   // Error status checks
   // -----------------------------------------------
   a_err_char: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (!err_block && i_head_pop && !rst_err) |=> err_q == $past(i_head_err))
      else $error("char mode error wrong");

   a_err_block: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (err_block && !rst_err) |=> (err_q & $past(err_q)) == $past(err_q))
      else $error("block mode error lost");

   // The reset command loses only to a head pop in block mode
   a_err_reset: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (rst_err && !i_head_pop) |=> (err_q == 4'h0))
      else $error("error reset ignored");

   // -----------------------------------------------
   // Decode checks
   // -----------------------------------------------
   a_req_src: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      mode1_q[REQ_SRC_BIT] |-> (o_rx_request == i_fifo_full)) else $error("request source wrong");

   a_req_ready: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !mode1_q[REQ_SRC_BIT] |-> (o_rx_request == i_rx_ready)) else $error("ready source wrong");

   a_data_bits: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      o_data_bits == 4'h5 + {2'b00, bc}) else $error("bit count wrong");

   a_bits_eight: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (bc == 2'b11) |-> (o_data_bits == 4'h8)) else $error("longest length wrong");

   a_parity_with: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (pm == PM_WITH) |-> (o_parity_enable && (o_parity_sel == (pt ? PAR_ODD : PAR_EVEN))))
      else $error("even or odd parity wrong");

   a_parity_none: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (pm == PM_NONE) |-> (!o_parity_enable && !o_multidrop)) else $error("parity not disabled");

   a_parity_multi: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (pm == PM_MULTI) |-> (o_multidrop && (o_parity_sel == (pt ? PAR_HIGH : PAR_LOW))))
      else $error("multidrop select wrong");

   // -----------------------------------------------
   // Interrupt and read port checks
   // -----------------------------------------------
   // Set must win over a clear in the same cycle
   a_irq_sticky: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (|irq_evt) |=> ((irq_stat_q & $past(irq_evt)) == $past(irq_evt)))
      else $error("interrupt event lost");

   a_irq_masked: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (irq_mask_q == 4'h0) |-> !o_irq) else $error("masked interrupt raised");

   // Read data stand for one cycle only, zero otherwise
   a_rdata_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !i_rd |=> (o_rdata == 8'h00)) else $error("read data outside read cycle");

   // -----------------------------------------------
   // Coverage of the main scenarios
   // -----------------------------------------------
   c_rts_drop: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      rts_hold_q ##[1:20] !rts_hold_q);
   c_ptr_cycle: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      mode1_acc ##[1:10] rst_ptr);
   c_block_acc: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      err_block && i_head_pop ##1 i_head_pop);
   c_flow_clash: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      flow_clash ##1 !flow_clash);
   c_addr_char: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      o_multidrop && !err_block && i_head_pop && i_head_addr);
endmodule : uart_mode_config_first

// >>> tb/remote_tx_model.sv
module remote_tx_model (
   // Clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_rst_n,
   // Flow control and enable
   input  wire logic i_clear_to_send_in,
   input  wire logic i_enable,
   // Character start towards the receiver
   output logic      o_start_bit
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] gap_q;
   // ----------------------------------------
   // One character start every four cycles
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         gap_q       <= 2'h0;
         o_start_bit <= 1'b0;
      end else begin
         gap_q       <= gap_q + 2'h1;
         // Holds off while clear-to-send is negated, so the receiver never overruns
         o_start_bit <= i_enable && i_clear_to_send_in && (gap_q == 2'h3);
      end
   end
endmodule : remote_tx_model

// >>> tb/uart_mode_config_first_tb.sv
module uart_mode_config_first_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import mode_one_pkg::*;
   typedef struct packed {
      logic [7:0] m;
      logic [1:0] sel;
      logic       en;
      logic       md;
      logic [3:0] bits;
      logic       rq;
   } row_t;
   logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_start_bit, i_fifo_full = 1'b0;
   logic i_head_pop = 1'b0, i_head_addr = 1'b0, tx_en = 1'b0, ok, any_start;
   logic i_rx_ready = 1'b1, i_rts_manual = 1'b1;
   logic [3:0] i_addr = 4'h0, i_head_err = 4'h0, o_data_bits;
   logic [7:0] i_wdata = 8'h00, o_rdata;
   logic o_request_to_send_out, o_rx_request, o_parity_enable, o_multidrop, o_tx_flow_active, o_irq;
   parity_sel_t o_parity_sel;
   int bad_count = 0, n_compared = 0, cycles = 0;
   row_t rows [7] = '{'{8'h00, 2'h0, 1, 0, 4'h5, 1}, '{8'h05, 2'h1, 1, 0, 4'h6, 1},
                      '{8'h4a, 2'h2, 1, 0, 4'h7, 0}, '{8'h0f, 2'h3, 1, 0, 4'h8, 1},
                      '{8'h10, 2'h0, 0, 0, 4'h5, 1}, '{8'h18, 2'h2, 1, 1, 4'h5, 1},
                      '{8'h1c, 2'h3, 1, 1, 4'h5, 1}};
   uart_mode_config_first u_uart_mode_config_first (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_start_bit(i_start_bit),
      .i_fifo_full(i_fifo_full), .i_rx_ready(i_rx_ready), .i_head_pop(i_head_pop), .i_head_err(i_head_err),
      .i_head_addr(i_head_addr), .i_rts_manual(i_rts_manual), .o_request_to_send_out(o_request_to_send_out),
      .o_rx_request(o_rx_request), .o_parity_sel(o_parity_sel), .o_parity_enable(o_parity_enable),
      .o_multidrop(o_multidrop), .o_data_bits(o_data_bits), .o_tx_flow_active(o_tx_flow_active), .o_irq(o_irq));
   remote_tx_model u_remote_tx_model (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
      .i_clear_to_send_in(o_request_to_send_out), .i_enable(tx_en), .o_start_bit(i_start_bit));
   initial begin
      forever #12.5 i_ref_clk = ~i_ref_clk;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_ref_clk) begin i_wr <= 1'b1; i_addr <= a; i_wdata <= d; end
      @(posedge i_ref_clk) i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge i_ref_clk) begin i_rd <= 1'b1; i_addr <= a; end
      @(posedge i_ref_clk) i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask : rd
   task automatic set_mode(input logic [7:0] v);
      wr(CMD_ADDR, 8'h10);
      wr(MODE_ADDR, v);
      @(posedge i_ref_clk);
   endtask : set_mode
   task automatic pop(input logic [3:0] e, input logic a);
      @(posedge i_ref_clk) begin i_head_pop <= 1'b1; i_head_err <= e; i_head_addr <= a; end
      @(posedge i_ref_clk) i_head_pop <= 1'b0;
   endtask : pop
   task automatic hold_high(input int n);
      ok = 1'b1;
      any_start = 1'b0;
      repeat (n) @(posedge i_ref_clk) begin
         ok &= o_request_to_send_out;
         any_start |= i_start_bit;
      end
   endtask : hold_high
   task automatic summarize;
      if (bad_count == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         summarize();
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [7:0] d;
      repeat (16) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      #1 check(o_data_bits, 8'h05);
      check(o_irq, 0);
      rd(MODE_ADDR, d); check(d, MODE1_RESET);
      foreach (rows[k]) begin
         set_mode(rows[k].m);
         check(o_data_bits, rows[k].bits);
         check(o_multidrop, rows[k].md);
         check(o_rx_request, rows[k].rq);
         if (!rows[k].md) check(o_parity_enable, rows[k].en);
         if (rows[k].en) check(o_parity_sel, rows[k].sel);
      end
      // Ready as request source follows the ready level
      i_rx_ready <= 1'b0;
      @(posedge i_ref_clk) #1 check(o_rx_request, 0);
      @(posedge i_ref_clk) i_rx_ready <= 1'b1;
      // Pointer walk: first access reaches mode one, the next mode two
      set_mode(8'h9c);
      wr(MODE_ADDR, 8'h2a);
      rd(MODE2_ADDR, d); check(d, 8'h2a);
      wr(CMD_ADDR, 8'h10);
      rd(MODE_ADDR, d); check(d, 8'h9c);
      rd(MODE_ADDR, d); check(d, 8'h2a);
      // Flow off: a start bit into a full FIFO leaves RTS alone
      wr(MODE2_ADDR, 8'h00);
      set_mode(8'h00);
      i_fifo_full <= 1'b1; tx_en <= 1'b1;
      hold_high(12); check(ok, 1);
      check(any_start, 1);
      i_rts_manual <= 1'b0;
      @(posedge i_ref_clk) #1 check(o_request_to_send_out, 0);
      @(posedge i_ref_clk) i_rts_manual <= 1'b1;
      tx_en <= 1'b0;
      // Flow on with the drop event unmasked
      wr(IRQ_MASK_ADDR, 8'h02);
      set_mode(8'h80);
      tx_en <= 1'b1;
      hold_high(10); check(ok, 0);
      #1 check(o_request_to_send_out, 0);
      check(o_irq, 1);
      rd(IRQ_STAT_ADDR, d); check(d & 8'h02, 8'h02);
      hold_high(8); check(ok, 0);
      check(any_start, 0);
      @(posedge i_ref_clk) i_fifo_full <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      #1 check(o_request_to_send_out, 1);
      tx_en <= 1'b0;
      wr(IRQ_STAT_ADDR, 8'h0f);
      repeat (2) @(posedge i_ref_clk);
      #1 check(o_irq, 0);
      // Both sources enabled: neither may drop RTS
      wr(MODE2_ADDR, 8'h20);
      i_fifo_full <= 1'b1; tx_en <= 1'b1;
      hold_high(12); check(ok, 1);
      check(o_tx_flow_active, 0);
      check(any_start, 1);
      tx_en <= 1'b0; i_fifo_full <= 1'b0;
      wr(MODE2_ADDR, 8'h00);
      // Error reporting, character then block mode
      set_mode(8'h00);
      pop(4'h1, 1'b0); pop(4'h2, 1'b0);
      rd(STAT_ADDR, d); check(d, 8'h02);
      set_mode(8'h20);
      pop(4'h1, 1'b0); pop(4'h2, 1'b0);
      rd(STAT_ADDR, d); check(d, 8'h03);
      wr(CMD_ADDR, 8'h40);
      rd(STAT_ADDR, d); check(d, 8'h00);
      set_mode(8'h18);
      pop(4'h0, 1'b1);
      rd(STAT_ADDR, d); check(d, 8'h20);
      rd(4'hf, d); check(d, 8'h00);
      // Mid-run reset: pointer and both mode registers return to reset values
      wr(MODE2_ADDR, 8'h2a);
      @(posedge i_ref_clk) i_rst_n <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      #1 check(o_request_to_send_out, 1);
      rd(PTR_ADDR, d); check(d, 8'h00);
      rd(MODE_ADDR, d); check(d, MODE1_RESET);
      rd(MODE_ADDR, d); check(d, MODE2_RESET);
      summarize();
   end
endmodule : uart_mode_config_first_tb
